// ==== rtl/ahb_reg_port.sv ====
// AHB-Lite slave front end: decodes transfers into register strobes
// assumes single word transfers; reads take one wait state
`timescale 1ns/1ps
module ahb_reg_port
  import txdesc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register side
  output txdesc_pkg::reg_wr_t wr,
  output logic [txdesc_pkg::REG_AW-1:0] rd_addr,
  input wire logic [31:0] rd_value
);
  logic ph_valid;
  logic ph_write;
  logic ph_word;
  logic [REG_AW-1:0] ph_addr;
  logic rd_done;
  logic rd_stall;

  // the wait state keeps read data in a flop and sees a write just before it
  assign rd_stall = ph_valid && !ph_write && !rd_done;
  assign hreadyout = !rd_stall;
  assign hresp = 1'b0;
  assign rd_addr = ph_addr;
  assign wr.en = ph_valid && ph_write && ph_word;
  assign wr.addr = ph_addr;
  assign wr.data = hwdata;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_word <= 1'b0;
      ph_addr <= '0;
      rd_done <= 1'b0;
      hrdata <= '0;
    end else begin
      if (hready) begin
        ph_valid <= hsel && htrans[1];
        ph_write <= hwrite;
        ph_word <= (hsize == HSIZE_WORD);
        ph_addr <= haddr[REG_AW-1:0];
      end
      rd_done <= rd_stall;
      if (rd_stall) begin
        hrdata <= rd_value;
      end
    end
  end
endmodule

// ==== rtl/buffer_walker.sv ====
// walks one transmit buffer: byte address and remaining count
// assumes the count is loaded as the two's complement of the length
`timescale 1ns/1ps
module buffer_walker
  import txdesc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic load,
  input wire logic step,
  input wire logic [txdesc_pkg::ADDR_W-1:0] base,
  input wire logic [txdesc_pkg::BUFFER_BYTE_COUNT_W-1:0] count_neg,
  // state
  output logic [txdesc_pkg::ADDR_W-1:0] addr,
  output logic done
);
  logic [BUFFER_BYTE_COUNT_W-1:0] remaining;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr <= '0;
      remaining <= '0;
    end else if (load) begin
      addr <= base;
      remaining <= count_neg;
    end else if (step) begin
      addr <= addr + ADDR_W'(1);
      remaining <= remaining + BUFFER_BYTE_COUNT_W'(1);
    end
  end

  // a zero count means an empty buffer, which is legal
  assign done = (remaining == '0);
endmodule

// ==== rtl/tx_descriptor_status_handler.sv ====
// transmit descriptor engine: polls the ring, chains buffers, writes status
// assumes a 16-bit memory port with held request and one-cycle ack pulse
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module tx_descriptor_status_handler
  import txdesc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // ahb-lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // descriptor and buffer memory master
  output logic mem_req,
  output logic mem_we,
  output logic [txdesc_pkg::ADDR_W-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // frame byte stream towards the transmit fifo
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_first,
  output logic tx_fcs,
  output logic tx_end,
  output logic tx_abort,
  // media side status
  input wire logic fifo_underflow,
  input wire logic channel_busy,
  input wire logic late_collision,
  input wire logic retry_failure,
  output logic retry_allowed,
  output logic transmitter_on
);
  typedef enum logic [10:0] {
    S_IDLE      = 11'h001,
    S_POLL_RD   = 11'h002,
    S_POLL_WAIT = 11'h004,
    S_RD0       = 11'h008,
    S_RD2       = 11'h010,
    S_FETCH_RD  = 11'h020,
    S_FETCH_OUT = 11'h040,
    S_PEEK      = 11'h080,
    S_WB3       = 11'h100,
    S_WB1S      = 11'h200,
    S_WB1       = 11'h400
  } state_t;

  state_t state;
  state_t next_state;
  reg_wr_t wr;
  logic [REG_AW-1:0] rd_addr;
  logic [31:0] rd_value;
  logic global_tx_checksum_disable;
  logic disable_stop_on_underflow;
  logic [ADDR_W-1:0] ring_base;
  logic [IDX_W-1:0] ring_len;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] idx_inc;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] ev_set;
  logic [POLL_W-1:0] poll_cnt;
  tx_desc_word1_t rd1;
  tx_desc_word1_t cur1;
  tx_desc_word1_t nxt1;
  tx_desc_word1_t wb1;
  tx_desc_word3_t wb3;
  logic [15:0] buf_lo;
  logic [ADDR_W-1:0] walk_addr;
  logic walk_done;
  logic walk_load;
  logic walk_step;
  logic underflow_flag_seen;
  logic late_collision_flag_seen;
  logic retry_failure_flag_seen;
  logic def_seen;
  logic first_pending;
  logic chain_ok;
  logic st_berr;
  logic st_underflow_flag;
  logic in_frame;
  logic underflow_flag_any;
  logic peek_fail;
  logic berr_now;
  logic underflow_flag_now;
  logic wb_entry;
  logic err_stop;
  logic frame_start;
  logic skip_desc;
  logic ctrl_wr;

  ahb_reg_port u_bus (
    .clk(clk),
    .arst_n(arst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_value(rd_value)
  );

  buffer_walker u_walk (
    .clk(clk),
    .arst_n(arst_n),
    .load(walk_load),
    .step(walk_step),
    .base({cur1.buffer_addr_high, buf_lo}),
    .count_neg(mem_rdata[BUFFER_BYTE_COUNT_W-1:0]),
    .addr(walk_addr),
    .done(walk_done)
  );

  function automatic logic [ADDR_W-1:0] desc_addr(input logic [IDX_W-1:0] i);
    desc_addr = ring_base + {{(ADDR_W - IDX_W - DESC_SHIFT){1'b0}}, i, {DESC_SHIFT{1'b0}}};
  endfunction

  assign rd1 = mem_rdata;
  assign ctrl_wr = wr.en && (wr.addr == CTRL_OFS);
  assign idx_inc = (idx + IDX_W'(1) >= ring_len) ? '0 : idx + IDX_W'(1);
  assign in_frame = !(state inside {S_IDLE, S_POLL_RD, S_POLL_WAIT});
  assign underflow_flag_any = underflow_flag_seen || (fifo_underflow && in_frame);
  // a held next descriptor is the only way to continue a chain
  assign peek_fail = (state == S_PEEK) && mem_ack && !rd1.holder;
  // underflow in a buffer that is not the last one means the next status came too late
  assign berr_now = peek_fail || (underflow_flag_any && !cur1.last_buffer_flag);
  assign underflow_flag_now = underflow_flag_any || berr_now;
  assign wb_entry = (next_state == S_WB3) && (state != S_WB3);
  assign err_stop = wb_entry && underflow_flag_now && !disable_stop_on_underflow;
  assign frame_start = (state == S_POLL_RD) && mem_ack && rd1.holder && rd1.first_buffer_flag;
  assign skip_desc = (state == S_POLL_RD) && mem_ack && rd1.holder && !rd1.first_buffer_flag;
  assign walk_load = (state == S_RD2) && mem_ack;
  assign walk_step = (state == S_FETCH_OUT) && tx_ready && !underflow_flag_seen;
  assign tx_valid = (state == S_FETCH_OUT) && !underflow_flag_seen;
  assign retry_allowed = !late_collision_flag_seen;

  // next state
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (transmitter_on) begin
          next_state = S_POLL_RD;
        end
      end
      S_POLL_RD: begin
        if (frame_start) begin
          next_state = S_RD0;
        end else if (mem_ack && !rd1.holder) begin
          next_state = S_POLL_WAIT;
        end
      end
      S_POLL_WAIT: begin
        if (!transmitter_on) begin
          next_state = S_IDLE;
        end else if (poll_cnt == '0) begin
          next_state = S_POLL_RD;
        end
      end
      S_RD0: begin
        if (mem_ack) begin
          next_state = S_RD2;
        end
      end
      S_RD2: begin
        if (mem_ack) begin
          next_state = S_FETCH_RD;
        end
      end
      S_FETCH_RD: begin
        if (walk_done) begin
          next_state = (cur1.last_buffer_flag || underflow_flag_any) ? S_WB3 : S_PEEK;
        end else if (mem_ack) begin
          next_state = underflow_flag_any ? S_WB3 : S_FETCH_OUT;
        end
      end
      S_FETCH_OUT: begin
        if (underflow_flag_any) begin
          next_state = S_WB3;
        end else if (tx_ready) begin
          next_state = S_FETCH_RD;
        end
      end
      S_PEEK: begin
        if (mem_ack) begin
          next_state = S_WB3;
        end
      end
      S_WB3: begin
        if (mem_ack) begin
          next_state = S_WB1S;
        end
      end
      S_WB1S: begin
        if (mem_ack) begin
          next_state = S_WB1;
        end
      end
      S_WB1: begin
        if (mem_ack) begin
          if (chain_ok) begin
            next_state = S_RD0;
          end else begin
            next_state = transmitter_on ? S_POLL_RD : S_IDLE;
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // memory port; request and address hold until the ack
  always_comb begin
    mem_req = 1'b1;
    mem_we = 1'b0;
    mem_addr = desc_addr(idx);
    case (state)
      S_POLL_RD: mem_addr = desc_addr(idx) + W1_OFS;
      S_RD0: mem_addr = desc_addr(idx) + W0_OFS;
      S_RD2: mem_addr = desc_addr(idx) + W2_OFS;
      S_FETCH_RD: begin
        mem_addr = walk_addr;
        mem_req = !walk_done;
      end
      S_PEEK: mem_addr = desc_addr(idx_inc) + W1_OFS;
      S_WB3: begin
        mem_addr = desc_addr(idx) + W3_OFS;
        mem_we = 1'b1;
      end
      S_WB1S, S_WB1: begin
        mem_addr = desc_addr(idx) + W1_OFS;
        mem_we = 1'b1;
      end
      default: mem_req = 1'b0;
    endcase
  end

  // host-owned fields are copied back exactly as read
  always_comb begin
    wb1 = cur1;
    wb1.err = st_underflow_flag || st_berr || late_collision_flag_seen || retry_failure_flag_seen;
    wb1.deferred_flag = def_seen;
    wb1.holder = (state == S_WB1S);
    wb3 = '0;
    wb3.buffer_error_flag = st_berr;
    wb3.underflow_flag = st_underflow_flag;
    wb3.late_collision_flag = late_collision_flag_seen;
    wb3.retry_failure_flag = retry_failure_flag_seen;
    mem_wdata = (state == S_WB3) ? wb3 : wb1;
  end

  // descriptor words and ring position
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur1 <= '0;
      nxt1 <= '0;
      buf_lo <= '0;
      idx <= '0;
      chain_ok <= 1'b0;
    end else begin
      if (wr.en && (wr.addr == RING_BASE_OFS)) begin
        idx <= '0;
      end else if (skip_desc || ((state == S_WB1) && mem_ack)) begin
        idx <= idx_inc;
      end
      if (frame_start) begin
        cur1 <= rd1;
      end else if ((state == S_WB1) && mem_ack && chain_ok) begin
        cur1 <= nxt1;
      end
      if ((state == S_RD0) && mem_ack) begin
        buf_lo <= mem_rdata;
      end
      if ((state == S_PEEK) && mem_ack) begin
        nxt1 <= rd1;
      end
      if (wb_entry) begin
        chain_ok <= (state == S_PEEK) && !berr_now && !underflow_flag_now;
      end
    end
  end

  // frame error and status gathering
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      underflow_flag_seen <= 1'b0;
      late_collision_flag_seen <= 1'b0;
      retry_failure_flag_seen <= 1'b0;
      def_seen <= 1'b0;
      first_pending <= 1'b0;
      st_berr <= 1'b0;
      st_underflow_flag <= 1'b0;
    end else begin
      if (frame_start) begin
        underflow_flag_seen <= 1'b0;
        late_collision_flag_seen <= 1'b0;
        retry_failure_flag_seen <= 1'b0;
        def_seen <= 1'b0;
        first_pending <= 1'b1;
      end else begin
        underflow_flag_seen <= underflow_flag_any;
        late_collision_flag_seen <= late_collision_flag_seen || (late_collision && in_frame);
        retry_failure_flag_seen <= retry_failure_flag_seen || (retry_failure && in_frame);
        if ((state == S_FETCH_OUT) && first_pending && channel_busy) begin
          def_seen <= 1'b1;
        end
        if (walk_step) begin
          first_pending <= 1'b0;
        end
      end
      if (wb_entry) begin
        st_berr <= berr_now;
        st_underflow_flag <= underflow_flag_now;
      end
    end
  end

  // stream data and frame markers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_data <= '0;
      tx_first <= 1'b0;
      tx_fcs <= 1'b0;
      tx_end <= 1'b0;
      tx_abort <= 1'b0;
    end else begin
      if ((state == S_FETCH_RD) && mem_ack) begin
        tx_data <= mem_rdata[7:0];
        tx_first <= first_pending;
      end
      if (frame_start) begin
        tx_fcs <= rd1.frame_check_insert || !global_tx_checksum_disable;
      end
      // only the last buffer closes the frame; chained buffers must not end it early
      tx_end <= wb_entry && !underflow_flag_now && cur1.last_buffer_flag;
      tx_abort <= wb_entry && underflow_flag_now;
    end
  end

  // poll spacing while the ring head is still with the host
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      poll_cnt <= '0;
    end else if (next_state == S_POLL_WAIT && state != S_POLL_WAIT) begin
      poll_cnt <= POLL_LOAD;
    end else if (poll_cnt != '0) begin
      poll_cnt <= poll_cnt - POLL_W'(1);
    end
  end

  // software registers; an error stop wins over a start in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transmitter_on <= 1'b0;
      global_tx_checksum_disable <= 1'b0;
      disable_stop_on_underflow <= 1'b0;
      ring_base <= RING_BASE_RST;
      ring_len <= RING_LEN_RST;
    end else begin
      if (err_stop) begin
        transmitter_on <= 1'b0;
      end else if (ctrl_wr && wr.data[CTRL_STOP_BIT]) begin
        transmitter_on <= 1'b0;
      end else if (ctrl_wr && wr.data[CTRL_START_BIT]) begin
        transmitter_on <= 1'b1;
      end
      if (ctrl_wr) begin
        global_tx_checksum_disable <= wr.data[CTRL_GDIS_BIT];
        disable_stop_on_underflow <= wr.data[CTRL_DSU_BIT];
      end
      if (wr.en && (wr.addr == RING_BASE_OFS)) begin
        ring_base <= wr.data[ADDR_W-1:0];
      end
      if (wr.en && (wr.addr == RING_LEN_OFS)) begin
        ring_len <= wr.data[IDX_W-1:0];
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_comb begin
    ev_set = '0;
    ev_set[EV_DONE_BIT] = (state == S_WB1) && mem_ack;
    ev_set[EV_DEFER_BIT] = wb_entry && def_seen;
    ev_set[EV_UFLOW_BIT] = wb_entry && underflow_flag_now;
    ev_set[EV_BERR_BIT] = wb_entry && berr_now;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      events <= '0;
    end else if (wr.en && (wr.addr == EVENT_OFS)) begin
      events <= (events & ~wr.data[EV_W-1:0]) | ev_set;
    end else begin
      events <= events | ev_set;
    end
  end

  always_comb begin
    rd_value = '0;
    case (rd_addr)
      CTRL_OFS: begin
        rd_value[CTRL_GDIS_BIT] = global_tx_checksum_disable;
        rd_value[CTRL_DSU_BIT] = disable_stop_on_underflow;
      end
      RING_BASE_OFS: rd_value[ADDR_W-1:0] = ring_base;
      RING_LEN_OFS: rd_value[IDX_W-1:0] = ring_len;
      STATUS_OFS: begin
        rd_value[STAT_TRANSMITTER_ON_BIT] = transmitter_on;
        rd_value[STAT_BUSY_BIT] = in_frame;
        rd_value[STAT_IDX_LSB +: IDX_W] = idx;
      end
      EVENT_OFS: rd_value[EV_W-1:0] = events;
      default: rd_value = '0;
    endcase
  end
endmodule

// ==== rtl/txdesc_pkg.sv ====
// shared constants and types for the transmit descriptor handler
// assumes a 50 MHz system clock and 16-bit descriptor words in memory
package txdesc_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int POLL_TIME_NS = 1600;
  localparam int POLL_CYCLES = (POLL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_W = 8;
  localparam logic [POLL_W-1:0] POLL_LOAD = POLL_W'(POLL_CYCLES - 1);
  localparam int ADDR_W = 24;
  localparam int BUFFER_BYTE_COUNT_W = 12;
  localparam int IDX_W = 8;
  localparam int DESC_SHIFT = 3;
  localparam logic [ADDR_W-1:0] W0_OFS = 24'h000000;
  localparam logic [ADDR_W-1:0] W1_OFS = 24'h000002;
  localparam logic [ADDR_W-1:0] W2_OFS = 24'h000004;
  localparam logic [ADDR_W-1:0] W3_OFS = 24'h000006;
  localparam int REG_AW = 5;
  localparam logic [REG_AW-1:0] CTRL_OFS = 5'h00;
  localparam logic [REG_AW-1:0] RING_BASE_OFS = 5'h04;
  localparam logic [REG_AW-1:0] RING_LEN_OFS = 5'h08;
  localparam logic [REG_AW-1:0] STATUS_OFS = 5'h0C;
  localparam logic [REG_AW-1:0] EVENT_OFS = 5'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_GDIS_BIT = 2;
  localparam int CTRL_DSU_BIT = 6;
  localparam int STAT_TRANSMITTER_ON_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_IDX_LSB = 8;
  localparam int EV_W = 4;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_DEFER_BIT = 1;
  localparam int EV_UFLOW_BIT = 2;
  localparam int EV_BERR_BIT = 3;
  localparam logic [ADDR_W-1:0] RING_BASE_RST = 24'h000000;
  localparam logic [IDX_W-1:0] RING_LEN_RST = 8'h01;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic holder;
    logic err;
    logic frame_check_insert;
    logic more;
    logic one;
    logic deferred_flag;
    logic first_buffer_flag;
    logic last_buffer_flag;
    logic [7:0] buffer_addr_high;
  } tx_desc_word1_t;

  typedef struct packed {
    logic buffer_error_flag;
    logic underflow_flag;
    logic res;
    logic late_collision_flag;
    logic carrier_lost;
    logic retry_failure_flag;
    logic [9:0] refl_count;
  } tx_desc_word3_t;

  typedef struct packed {
    logic en;
    logic [REG_AW-1:0] addr;
    logic [31:0] data;
  } reg_wr_t;
endpackage

// ==== testbench/host_mem_model.sv ====
// host memory model: descriptor rings and buffers, byte array, little endian
// decodes address bits 8:0 only; latency follows the lat input per request
`timescale 1ns/1ps
module host_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // answer latency
  input wire logic [1:0] lat
);
  logic [7:0] m [0:511];
  logic [1:0] cnt;
  logic [8:0] a;
  assign a = mem_addr[8:0];
  // outside an answer the data lines toggle so a stale word never looks valid
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      mem_rdata <= {m[a + 9'h1], m[a]};
      if (mem_we) begin
        m[a] <= mem_wdata[7:0];
        m[a + 9'h1] <= mem_wdata[15:8];
      end
    end else begin
      mem_ack <= 1'b0;
      cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench: plays the host, builds rings, checks stream and writebacks
// assumes the memory model decodes byte address bits 8:0 only
`timescale 1ns/1ps
module tb_top;
  import txdesc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, mem_req, mem_we, mem_ack, tx_valid, tx_first;
  logic tx_fcs, tx_end, tx_abort, retry_allowed, transmitter_on;
  logic [31:0] hrdata, rd;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [7:0] tx_data;
  logic tx_ready = 1'b0;
  logic fifo_underflow = 1'b0;
  logic channel_busy = 1'b0;
  logic late_collision = 1'b0;
  logic retry_failure = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [31:0] seed = 32'hA211;
  logic ended, aborted, rel, fcs_seen;
  int n_errors = 0;
  int n_checks = 0;
  int hi_reads;
  logic [7:0] q[$];
  logic [7:0] expq[$];
  assign hready = hreadyout;
  always #10 clk = ~clk;
  tx_descriptor_status_handler u_tx_descriptor_status_handler (.*);
  host_mem_model u_host_mem_model (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk) begin
    seed <= lfsr(seed);
    tx_ready <= seed[0] | seed[3];
    lat <= seed[5:4];
    if (tx_valid && tx_ready) begin
      q.push_back(tx_data);
      if (tx_first) fcs_seen <= tx_fcs;
    end
    if (tx_end) ended <= 1'b1;
    if (tx_abort) aborted <= 1'b1;
    if (mem_req && mem_ack && !mem_we && mem_addr[23:16] == 8'h5A) hi_reads++;
    if (mem_req && mem_ack && mem_we && mem_addr[2:0] == 3'h2 && !mem_wdata[15]) rel <= 1'b1;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // called right after a rising edge; hready and hrdata are read before the edge's updates land
  task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!hready);
    rd = hrdata;
  endtask
  task automatic put(input int a, input logic [15:0] v);
    u_host_mem_model.m[a] = v[7:0];
    u_host_mem_model.m[a + 1] = v[15:8];
  endtask
  function automatic logic [15:0] get(input int a);
    return {u_host_mem_model.m[a + 1], u_host_mem_model.m[a]};
  endfunction
  task automatic desc(input int a, input logic [15:0] w1, input logic [15:0] w0, input int n);
    logic [31:0] s;
    s = seed;
    put(a, w0);
    put(a + 4, {4'hF, 12'(-n)});
    put(a + 6, 16'h0000);
    for (int i = 0; i < n; i++) begin
      s = lfsr(s);
      u_host_mem_model.m[w0[8:0] + i] = s[7:0];
      expq.push_back(s[7:0]);
    end
    put(a + 2, w1);
  endtask
  task automatic clr;
    q.delete();
    ended = 1'b0;
    aborted = 1'b0;
    rel = 1'b0;
    hi_reads = 0;
  endtask
  task automatic waitrel;
    for (int i = 0; i < 4000 && !rel; i++) @(posedge clk);
    check("released", rel, 1'b1);
    repeat (4) @(posedge clk);
    foreach (q[i]) check("byte", q[i], expq[i]);
    expq.delete();
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #600000;
    n_errors++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    ahb(1'b0, RING_LEN_OFS, 32'h0);
    check("ring len", rd, 32'h1);
    ahb(1'b0, 5'h1C, 32'h0);
    check("unmapped", rd, 32'h0);
    // single buffer frame, nonzero high byte, checksum forced, channel busy
    clr;
    desc(0, 16'hA35A, 16'h0101, 5);
    channel_busy <= 1'b1;
    ahb(1'b1, CTRL_OFS, 32'h5);
    waitrel;
    channel_busy <= 1'b0;
    check("count a", q.size(), 5);
    check("end a", ended, 1'b1);
    check("fcs a", fcs_seen, 1'b1);
    check("high reads", hi_reads, 5);
    check("w1 a", get(2) & 16'hA7FF, 16'h275A);
    check("w2 a", get(4), 16'hFFFB);
    // skipped entry, then a chained buffer whose successor is still the host's
    clr;
    desc(64, 16'h8000, 16'h0000, 0);
    desc(72, 16'h8200, 16'h0080, 3);
    desc(80, 16'h0000, 16'h0000, 0);
    // stop first: moving the ring under a pending poll read would shift its address
    ahb(1'b1, CTRL_OFS, 32'h2);
    repeat (8) @(posedge clk);
    ahb(1'b1, RING_LEN_OFS, 32'h4);
    ahb(1'b1, RING_BASE_OFS, 32'h40);
    ahb(1'b1, CTRL_OFS, 32'h5);
    waitrel;
    check("count b", q.size(), 3);
    check("skip held", get(66), 16'h8000);
    check("fcs b", fcs_seen, 1'b0);
    check("w1 b", get(74) & 16'h87FF, 16'h0200);
    check("w3 b", get(78) & 16'hC000, 16'hC000);
    check("abort b", aborted, 1'b1);
    check("transmitter_on b", transmitter_on, 1'b0);
    ahb(1'b0, EVENT_OFS, 32'h0);
    check("events", rd[3:2], 2'h3);
    ahb(1'b1, EVENT_OFS, 32'hF);
    // late data mid-frame with stop on underflow disabled
    clr;
    desc(192, 16'h8300, 16'h01A0, 6);
    ahb(1'b1, RING_LEN_OFS, 32'h1);
    ahb(1'b1, RING_BASE_OFS, 32'hC0);
    ahb(1'b1, CTRL_OFS, 32'h41);
    for (int i = 0; i < 3000 && q.size() < 2; i++) @(posedge clk);
    fifo_underflow <= 1'b1;
    late_collision <= 1'b1;
    @(posedge clk);
    fifo_underflow <= 1'b0;
    late_collision <= 1'b0;
    waitrel;
    check("w3 c", get(198), 16'h5000);
    check("retry c", retry_allowed, 1'b0);
    check("truncated", aborted && !ended, 1'b1);
    check("transmitter_on c", transmitter_on, 1'b1);
    finish_test;
  end
endmodule

// ==== testbench/txdesc_sva.sv ====
// assertion checker for the transmit descriptor handler, bound to its top module
// sees only top-level ports; descriptors are assumed 8-byte aligned in memory
`timescale 1ns/1ps
module txdesc_sva (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [txdesc_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // byte stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_abort,
  input wire logic fifo_underflow
);
  logic arm;
  logic was_w0;
  logic w3_done;
  logic [7:0] hi;
  logic [15:0] lo;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // tracks descriptor fetch order so the first buffer read can be predicted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arm <= 1'b0;
      was_w0 <= 1'b0;
      w3_done <= 1'b0;
      hi <= 8'h00;
      lo <= 16'h0000;
    end else if (mem_req && mem_ack && mem_we) begin
      if (mem_addr[2:0] == 3'h6) begin
        w3_done <= 1'b1;
      end else if (!mem_wdata[15]) begin
        w3_done <= 1'b0;
      end
    end else if (mem_req && mem_ack) begin
      arm <= !arm && was_w0 && mem_addr[2:0] == 3'h4;
      was_w0 <= mem_addr[2:0] == 3'h0;
      if (mem_addr[2:0] == 3'h2) begin
        hi <= mem_rdata[7:0];
      end
      if (mem_addr[2:0] == 3'h0) begin
        lo <= mem_rdata;
      end
    end
  end
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request not held");
  tx_hold_a: assert property (tx_valid && !tx_ready && !fifo_underflow |=> tx_valid && $stable(tx_data))
    else $error("stream byte not held");
  uflow_drop_a: assert property (fifo_underflow && tx_valid |=> !tx_valid ##[0:200] tx_abort)
    else $error("underflow did not truncate frame");
  berr_underflow_flag_a: assert property (mem_req && mem_we && mem_addr[2:0] == 3'h6 && mem_wdata[15] |-> mem_wdata[14])
    else $error("buffer error without underflow");
  status_first_a: assert property (mem_req && mem_we && mem_addr[2:0] == 3'h2 && !mem_wdata[15] |-> w3_done)
    else $error("holder released before status");
  buf_addr_a: assert property (arm && mem_req |-> mem_addr == {hi, lo})
    else $error("buffer address not high byte plus low word");
endmodule

bind tx_descriptor_status_handler txdesc_sva u_txdesc_sva (.*);
